/* File: bench/reclocker_eye_checker.sv */
`timescale 1ns/1ps
module reclocker_eye_checker (
  input wire mclk,
  input wire reset,
  input wire spiSsN,
  input wire spiMisoOe,
  input wire sigDetRaw0,
  input wire sigDetPower0,
  input wire sigDetPower1,
  input wire sigDetected0,
  input wire inputSelect,
  input wire eqPower0,
  input wire eqPower1,
  input wire [7:0] eqBoostStages,
  input wire [3:0] eqBoostSum,
  input wire cdrRoute,
  input wire [9:0] cdrRateMask,
  input wire eyePower,
  input wire eyeActive,
  input wire [5:0] eyePhase,
  input wire [5:0] eyeVoltStep
);
  wire [11:0] point = {eyePhase, eyeVoltStep};
  default clocking @(posedge mclk);
  endclocking
  default disable iff (reset);
  AST_EQ_POWER: assert property (eqPower0 == !inputSelect && eqPower1 == inputSelect)
    else $error("equalizer power does not follow selection");
  AST_BOOST_SUM: assert property (eqBoostSum == eqBoostStages[7:6] + eqBoostStages[5:4]
    + eqBoostStages[3:2] + eqBoostStages[1:0])
    else $error("boost sum wrong");
  AST_RESET_VALUES: assert property ($past(reset) |-> sigDetPower0 && sigDetPower1
    && !inputSelect && cdrRoute && cdrRateMask == 10'h3ff)
    else $error("reset value wrong");
  AST_DET_UNPOWERED: assert property ((!sigDetPower0) [*3] |-> !sigDetected0)
    else $error("detector reports while off");
  AST_DET_FOLLOWS: assert property ((sigDetPower0 && $stable(sigDetRaw0)) [*6]
    |-> sigDetected0 == sigDetRaw0)
    else $error("detect does not follow input");
  AST_MISO_RELEASE: assert property (spiSsN [*4] |-> !spiMisoOe)
    else $error("data out driven while deselected");
  AST_EYE_UNPOWERED: assert property ((!eyePower) [*3] |-> !eyeActive)
    else $error("scan runs without power");
  AST_SCAN_STEP: assert property (eyeActive && $past(eyeActive) && $changed(point)
    |-> point == $past(point) + 12'h1)
    else $error("scan point skipped");
  AST_POINT_DWELL: assert property (eyeActive && $changed(point) |=> $stable(point) [*8])
    else $error("scan point too short");
endmodule
bind reclocker_input_eye_monitor reclocker_eye_checker reclocker_eye_checker_i (.mclk, .reset,
  .spiSsN, .spiMisoOe, .sigDetRaw0, .sigDetPower0, .sigDetPower1, .sigDetected0, .inputSelect,
  .eqPower0, .eqPower1, .eqBoostStages, .eqBoostSum, .cdrRoute, .cdrRateMask, .eyePower,
  .eyeActive, .eyePhase, .eyeVoltStep);

/* File: bench/reclocker_input_eye_monitor_tb.sv */
`timescale 1ns/1ps
`include "reclocker_ctrl_defines.vh"
module reclocker_input_eye_monitor_tb;
  logic mclk, reset, spiSsN, spiSck, spiMosi, spiMiso, spiMisoOe;
  logic sigDetRaw0, sigDetRaw1, eyeHitRaw, sigDetPower0, sigDetPower1;
  logic sigDetected0, sigDetected1, inputSelect, eqPower0, eqPower1, eqBypass;
  logic cdrEnable, cdrRoute, eyePower, eyeActive;
  logic [7:0] sigDetLevel0, sigDetLevel1, eqBoostStages, rx, ctl, l0, l1, b0, b1, sel;
  logic [3:0] eqBoostSum;
  logic [9:0] cdrRateMask;
  logic [2:0] eyeSpan;
  logic [5:0] eyePhase, eyeVoltStep;
  logic [15:0] v;
  logic [15:0] hitq[$];
  integer n_errors = 0, tests_run = 0, seed = 32'hf033, s;
  reclocker_input_eye_monitor reclocker_input_eye_monitor_i (.mclk, .reset, .spiSsN, .spiSck,
    .spiMosi, .spiMiso, .spiMisoOe, .sigDetRaw0, .sigDetRaw1, .eyeHitRaw, .sigDetPower0,
    .sigDetPower1, .sigDetLevel0, .sigDetLevel1, .sigDetected0, .sigDetected1, .inputSelect,
    .eqPower0, .eqPower1, .eqBypass, .eqBoostStages, .eqBoostSum, .cdrEnable, .cdrRoute,
    .cdrRateMask, .eyePower, .eyeSpan, .eyePhase, .eyeVoltStep, .eyeActive);
  spi_host_model spi_host_model_i (.mclk, .spiSsN, .spiSck, .spiMosi, .spiMiso, .spiMisoOe);
  // ********************************
  // Checking and bus helpers
  // ********************************
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    spi_host_model_i.open();
    spi_host_model_i.xbyte({1'b0, a}, rx);
    spi_host_model_i.xbyte(d, rx);
    spi_host_model_i.close();
    repeat (2) @(negedge mclk);
  endtask
  task automatic rd(input logic [6:0] a, input int n, output logic [15:0] d);
    spi_host_model_i.open();
    spi_host_model_i.xbyte({1'b1, a}, rx);
    d = 16'h0;
    repeat (n) begin
      spi_host_model_i.xbyte(8'h00, rx);
      d = {d[7:0], rx};
    end
    spi_host_model_i.close();
  endtask
  task automatic eyeRead(input logic [15:0] exp);
    int k = 0;
    v = 16'h1;
    while (v[0] && k < 40) begin
      rd(`REG_EYE_CONTROL, 1, v);
      k++;
    end
    rd(`REG_EYE_HITS_HIGH, 2, v);
    check("eyeHits", v, exp);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    repeat (60000) @(negedge mclk);
    n_errors++;
    summarize();
  end
  // ********************************
  // Scenarios
  // ********************************
  initial begin
    reset = 1'b1;
    sigDetRaw0 = 1'b0;
    sigDetRaw1 = 1'b0;
    eyeHitRaw = 1'b0;
    repeat (5) @(negedge mclk);
    reset = 1'b0;
    repeat (4) @(negedge mclk);
    check("detPower", {sigDetPower1, sigDetPower0}, 16'h3);
    check("select", {inputSelect, eqPower1, eqPower0}, 16'h1);
    check("route", {cdrRoute, cdrRateMask}, 16'h7ff);
    rd(`REG_DETECT_LEVEL0, 2, v);
    check("levels", v, 16'h4040);
    wr(7'h30, 8'h5a);
    rd(7'h30, 1, v);
    check("unmapped", v, 16'h0);
    repeat (4) begin
      ctl = $random(seed) & 8'h1f;
      {l0, l1, b0, b1} = $random(seed);
      sigDetRaw0 = $random(seed);
      sigDetRaw1 = $random(seed);
      wr(`REG_PATH_CONTROL, ctl);
      wr(`REG_DETECT_LEVEL0, l0);
      wr(`REG_DETECT_LEVEL1, l1);
      wr(`REG_EQ_BOOST0, b0);
      wr(`REG_EQ_BOOST1, b1);
      sel = ctl[0] ? b1 : b0;
      s = sel[7:6] + sel[5:4] + sel[3:2] + sel[1:0];
      check("eqPower", {inputSelect, eqPower1, eqPower0}, ctl[0] ? 16'h6 : 16'h1);
      check("stages", eqBoostStages, sel);
      check("sum", eqBoostSum, s[15:0]);
      check("bypass", eqBypass, ctl[1]);
      check("route", cdrRoute, !ctl[2]);
      check("lvl", {sigDetLevel1, sigDetLevel0}, {l1, l0});
      check("det", sigDetected0, sigDetRaw0 & ctl[3]);
      check("det1", sigDetected1, sigDetRaw1 & ctl[4]);
      check("detPwr", {sigDetPower1, sigDetPower0}, ctl[4:3]);
      rd(`REG_STATUS, 1, v);
      check("status", v[1:0], {sigDetRaw1 & ctl[4], sigDetRaw0 & ctl[3]});
    end
    wr(`REG_RATE_MASK_LO, l0);
    check("mask", cdrRateMask[7:0], l0);
    wr(`REG_RATE_MASK_HI, l1);
    check("maskHi", cdrRateMask, {l1[1:0], l0});
    for (int c = 0; c < 12; c++) begin
      wr(`REG_RATE_CODE, c[7:0]);
      check("cdrEn", cdrEnable, !(c == 10 || c == 11));
    end
    wr(`REG_EYE_SETUP, 8'h0e);
    check("span", {eyeSpan, eyePower}, 16'he);
    wr(`REG_PATH_CONTROL, 8'h18);
    wr(`REG_RATE_CODE, 8'h00);
    wr(`REG_EYE_SETUP, 8'h01);
    wr(`REG_EYE_OBSERVE, 8'h03);
    eyeHitRaw = 1'b1;
    wr(`REG_EYE_CONTROL, 8'h80);
    check("active", eyeActive, 1'b1);
    // Long stall so the two-entry buffer fills while the engine counts a third point
    repeat (2400) @(negedge mclk);
    // Every point sees a hit on each observed bit: (setting + 1) * 256
    repeat (5) hitq.push_back(16'((3 + 1) * 256));
    repeat (2) begin
      rd(`REG_EYE_HITS_HIGH, 2, v);
      void'(hitq.pop_front());
    end
    repeat (3) eyeRead(hitq.pop_front());
    rd(`REG_EYE_CONTROL, 1, v);
    check("busy", v[0], 1'b1);
    wr(`REG_RATE_CODE, 8'h08);
    check("lowRate", eyeActive, 1'b0);
    summarize();
  end
endmodule

/* File: bench/spi_host_model.sv */
`timescale 1ns/1ps
// ********************************
// SPI host, mode 0, 200 ns clock
// ********************************
module spi_host_model (
  input wire mclk,
  output logic spiSsN,
  output logic spiSck,
  output logic spiMosi,
  input wire spiMiso,
  input wire spiMisoOe
);
  initial begin
    spiSsN = 1'b1;
    spiSck = 1'b0;
    spiMosi = 1'b0;
  end
  task automatic open();
    spiSsN = 1'b0;
    repeat (4) @(negedge mclk);
  endtask
  // Released data line toggles so no stale bit looks valid
  task automatic close();
    spiSsN = 1'b1;
    spiMosi = ~spiMosi;
    repeat (4) @(negedge mclk);
  endtask
  // Reply sampled late in the high phase, after the device's sync delay
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int b = 7; b >= 0; b--) begin
      spiMosi = tx[b];
      repeat (4) @(negedge mclk);
      spiSck = 1'b1;
      repeat (4) @(negedge mclk);
      // Undriven line floats high, so a missing enable shows up as ones
      rx[b] = spiMisoOe ? spiMiso : 1'b1;
      spiSck = 1'b0;
    end
  endtask
endmodule

/* File: rtl/reclocker_ctrl_defines.vh */
`ifndef RECLOCKER_CTRL_DEFINES_VH
`define RECLOCKER_CTRL_DEFINES_VH
// ********************************
// Register offsets
// ********************************
`define REG_PATH_CONTROL 7'h00
`define REG_DETECT_LEVEL0 7'h01
`define REG_DETECT_LEVEL1 7'h02
`define REG_EQ_BOOST0 7'h03
`define REG_EQ_BOOST1 7'h04
`define REG_RATE_CODE 7'h05
`define REG_RATE_MASK_LO 7'h06
`define REG_RATE_MASK_HI 7'h07
`define REG_STATUS 7'h08
`define REG_EYE_SETUP 7'h09
`define REG_EYE_OBSERVE 7'h0a
`define REG_EYE_CONTROL 7'h24
`define REG_EYE_HITS_HIGH 7'h25
`define REG_EYE_HITS_LOW 7'h26
// ********************************
// Field positions
// ********************************
`define CTL_INPUT_SELECT 0
`define CTL_EQ_BYPASS 1
`define CTL_CDR_AROUND 2
`define CTL_DETECT0_POWER 3
`define CTL_DETECT1_POWER 4
`define EYE_POWER_BIT 0
`define EYE_FAST_BIT 7
`define EYE_BUSY_BIT 0
// ********************************
// Reset values
// ********************************
`define RST_PATH_CONTROL 8'h18
`define RST_DETECT_LEVEL 8'h40
`define RST_EQ_BOOST 8'h00
`define RST_RATE_CODE 4'h0
`define RST_RATE_MASK 10'h3ff
`define RST_EYE_SETUP 8'h00
`define RST_EYE_OBSERVE 8'h00
// ********************************
// Rate codes
// ********************************
`define RATE_1G4835 4'h7
`define RATE_10G3125 4'h9
`define RATE_125M 4'ha
`define RATE_1G25 4'hb
// ********************************
// Eye scan
// ********************************
`define EYE_LAST_POINT 12'hfff
`define EYE_BITS_PER_STEP 8'hff
`endif

/* File: rtl/reclocker_input_eye_monitor.v */
`timescale 1ns/1ps
`include "reclocker_ctrl_defines.vh"
// Operation
// - Two signal detectors, powered on after reset
// - Detector asserts on signal, drops on noise
// - Each detector threshold separately programmable
// - Input zero selected after reset, host switches
// - Four two-bit boost stages, boost is sum
// - Only selected input equalizer is powered
// - Equalizer bypass setting available
// - Equalized data routed into recovery by default
// - Recovery tries each enabled supported rate
// - 125M and 1.25G rates use recovery bypass
// - Eye monitor valid only at 1.4835G up
// - Eye scan walks 64 by 64 points
// - Eye voltage span programmable
// - Observed bits per point host configurable
// - Fast readout starts on control bit 7
// - Busy bit high until sample available
// - Reading low count byte frees a buffer entry; scan waits on it only when full
module reclocker_input_eye_monitor (
  input wire mclk,
  input wire reset,
  input wire spiSsN,
  input wire spiSck,
  input wire spiMosi,
  output reg spiMiso,
  output reg spiMisoOe,
  input wire sigDetRaw0,
  input wire sigDetRaw1,
  input wire eyeHitRaw,
  output reg sigDetPower0,
  output reg sigDetPower1,
  output reg [7:0] sigDetLevel0,
  output reg [7:0] sigDetLevel1,
  output reg sigDetected0,
  output reg sigDetected1,
  output reg inputSelect,
  output reg eqPower0,
  output reg eqPower1,
  output reg eqBypass,
  output reg [7:0] eqBoostStages,
  output reg [3:0] eqBoostSum,
  output reg cdrEnable,
  output reg cdrRoute,
  output reg [9:0] cdrRateMask,
  output reg eyePower,
  output reg [2:0] eyeSpan,
  output reg [5:0] eyePhase,
  output reg [5:0] eyeVoltStep,
  output reg eyeActive
);

  // ********************************
  // Helpers
  // ********************************
  function [3:0] boostSum;
    input [7:0] stages;
    begin
      boostSum = {2'b00, stages[1:0]} + {2'b00, stages[3:2]} +
        {2'b00, stages[5:4]} + {2'b00, stages[7:6]};
    end
  endfunction

  function eyeRateOk;
    input [3:0] code;
    begin
      eyeRateOk = (code <= `RATE_1G4835) || (code == `RATE_10G3125);
    end
  endfunction

  // ********************************
  // Registers
  // ********************************
  reg [7:0] pathControl;
  reg [7:0] eqBoost0;
  reg [7:0] eqBoost1;
  reg [3:0] rateCode;
  reg [7:0] eyeSetup;
  reg [7:0] eyeObserve;
  reg fastEnable;

  // ********************************
  // Input synchronisers
  // ********************************
  reg ssMeta;
  reg ssSync;
  reg sckMeta;
  reg sckSync;
  reg sckLast;
  reg mosiMeta;
  reg mosiSync;
  reg det0Meta;
  reg det0Sync;
  reg det1Meta;
  reg det1Sync;
  reg hitMeta;
  reg hitSync;

  always @(posedge mclk) begin
    ssMeta <= spiSsN;
    ssSync <= ssMeta;
    sckMeta <= spiSck;
    sckSync <= sckMeta;
    sckLast <= sckSync;
    mosiMeta <= spiMosi;
    mosiSync <= mosiMeta;
    det0Meta <= sigDetRaw0;
    det0Sync <= det0Meta;
    det1Meta <= sigDetRaw1;
    det1Sync <= det1Meta;
    hitMeta <= eyeHitRaw;
    hitSync <= hitMeta;
  end

  wire sckRise = sckSync & ~sckLast & ~ssSync;
  wire sckFall = ~sckSync & sckLast & ~ssSync;

  // ********************************
  // Two-entry count buffer
  // ********************************
  reg [15:0] fifoMem [0:1];
  reg fifoWrPtr;
  reg fifoRdPtr;
  reg [1:0] fifoCount;
  wire fifoInReady = (fifoCount != 2'd2);
  wire fifoOutValid = (fifoCount != 2'd0);
  wire [15:0] fifoHead = fifoMem[fifoRdPtr];
  reg engValid;
  reg [15:0] engCount;
  wire fifoPush = engValid & fifoInReady;
  reg fifoPop;

  always @(posedge mclk) begin
    if (reset || !fastEnable) begin
      fifoWrPtr <= 1'b0;
      fifoRdPtr <= 1'b0;
      fifoCount <= 2'd0;
    end else begin
      if (fifoPush) begin
        fifoMem[fifoWrPtr] <= engCount;
        fifoWrPtr <= ~fifoWrPtr;
      end
      if (fifoPop) fifoRdPtr <= ~fifoRdPtr;
      fifoCount <= fifoCount + {1'b0, fifoPush} - {1'b0, fifoPop};
    end
  end

  // ********************************
  // Eye scan engine
  // ********************************
  localparam ENG_IDLE = 2'd0;
  localparam ENG_RUN = 2'd1;
  localparam ENG_HOLD = 2'd2;
  reg [1:0] engState;
  reg [11:0] point;
  reg [15:0] bitCount;
  wire eyeRun = fastEnable & eyeSetup[`EYE_POWER_BIT] & eyeRateOk(rateCode);

  always @(posedge mclk) begin
    if (reset || !eyeRun) begin
      engState <= ENG_IDLE;
      point <= 12'h000;
      bitCount <= 16'h0000;
      engCount <= 16'h0000;
      engValid <= 1'b0;
    end else begin
      case (engState)
        ENG_IDLE: begin
          bitCount <= 16'h0000;
          engCount <= 16'h0000;
          engState <= ENG_RUN;
        end
        ENG_RUN: begin
          if (hitSync && engCount != 16'hffff) engCount <= engCount + 16'h0001;
          bitCount <= bitCount + 16'h0001;
          // Observed bits per point = (setting + 1) * 256
          if (bitCount == {eyeObserve, `EYE_BITS_PER_STEP}) begin
            engValid <= 1'b1;
            engState <= ENG_HOLD;
          end
        end
        ENG_HOLD: begin
          // Stalls here while the host has two counts unread
          if (fifoPush) begin
            engValid <= 1'b0;
            point <= (point == `EYE_LAST_POINT) ? 12'h000 : point + 12'h001;
            engState <= ENG_IDLE;
          end
        end
        default: engState <= ENG_IDLE;
      endcase
    end
  end

  // ********************************
  // Serial register port
  // ********************************
  reg [2:0] bitIndex;
  reg [7:0] rxShift;
  reg [7:0] txShift;
  reg [6:0] regAddr;
  reg isRead;
  reg gotAddr;
  reg [7:0] readData;
  wire [7:0] rxByte = {rxShift[6:0], mosiSync};
  wire byteDone = sckRise & (bitIndex == 3'd7);
  wire [6:0] nextAddr = gotAddr ? regAddr + 7'd1 : rxByte[6:0];
  wire loadRead = byteDone & (gotAddr ? isRead : rxByte[7]);
  wire doWrite = byteDone & gotAddr & ~isRead;

  always @* begin
    case (nextAddr)
      `REG_PATH_CONTROL: readData = pathControl;
      `REG_DETECT_LEVEL0: readData = sigDetLevel0;
      `REG_DETECT_LEVEL1: readData = sigDetLevel1;
      `REG_EQ_BOOST0: readData = eqBoost0;
      `REG_EQ_BOOST1: readData = eqBoost1;
      `REG_RATE_CODE: readData = {4'h0, rateCode};
      `REG_RATE_MASK_LO: readData = cdrRateMask[7:0];
      `REG_RATE_MASK_HI: readData = {6'h00, cdrRateMask[9:8]};
      `REG_STATUS: readData = {4'h0, eyeActive, cdrEnable, sigDetected1, sigDetected0};
      `REG_EYE_SETUP: readData = eyeSetup;
      `REG_EYE_OBSERVE: readData = eyeObserve;
      `REG_EYE_CONTROL: readData = {fastEnable, 6'h00, fastEnable & ~fifoOutValid};
      `REG_EYE_HITS_HIGH: readData = fifoOutValid ? fifoHead[15:8] : 8'h00;
      `REG_EYE_HITS_LOW: readData = fifoOutValid ? fifoHead[7:0] : 8'h00;
      default: readData = 8'h00;
    endcase
  end

  always @(posedge mclk) begin
    // Head only moves on the low byte, so a high/low burst is one count
    fifoPop <= loadRead & (nextAddr == `REG_EYE_HITS_LOW) & fifoOutValid & ~fifoPop;
    if (reset || ssSync) begin
      bitIndex <= 3'd0;
      gotAddr <= 1'b0;
      isRead <= 1'b0;
      regAddr <= 7'h00;
      rxShift <= 8'h00;
      txShift <= 8'h00;
      spiMiso <= 1'b0;
      spiMisoOe <= 1'b0;
    end else begin
      spiMisoOe <= 1'b1;
      if (sckRise) begin
        rxShift <= rxByte;
        bitIndex <= bitIndex + 3'd1;
      end
      if (byteDone) begin
        regAddr <= nextAddr;
        gotAddr <= 1'b1;
        if (!gotAddr) isRead <= rxByte[7];
      end
      if (loadRead) begin
        txShift <= readData;
      end else if (sckFall) begin
        spiMiso <= txShift[7];
        txShift <= {txShift[6:0], 1'b0};
      end
    end
  end

  // ********************************
  // Host writable settings
  // ********************************
  always @(posedge mclk) begin
    if (reset) begin
      pathControl <= `RST_PATH_CONTROL;
      sigDetLevel0 <= `RST_DETECT_LEVEL;
      sigDetLevel1 <= `RST_DETECT_LEVEL;
      eqBoost0 <= `RST_EQ_BOOST;
      eqBoost1 <= `RST_EQ_BOOST;
      rateCode <= `RST_RATE_CODE;
      cdrRateMask <= `RST_RATE_MASK;
      eyeSetup <= `RST_EYE_SETUP;
      eyeObserve <= `RST_EYE_OBSERVE;
      fastEnable <= 1'b0;
    end else if (doWrite) begin
      case (regAddr)
        `REG_PATH_CONTROL: pathControl <= rxByte;
        `REG_DETECT_LEVEL0: sigDetLevel0 <= rxByte;
        `REG_DETECT_LEVEL1: sigDetLevel1 <= rxByte;
        `REG_EQ_BOOST0: eqBoost0 <= rxByte;
        `REG_EQ_BOOST1: eqBoost1 <= rxByte;
        `REG_RATE_CODE: rateCode <= rxByte[3:0];
        `REG_RATE_MASK_LO: cdrRateMask[7:0] <= rxByte;
        `REG_RATE_MASK_HI: cdrRateMask[9:8] <= rxByte[1:0];
        `REG_EYE_SETUP: eyeSetup <= rxByte;
        `REG_EYE_OBSERVE: eyeObserve <= rxByte;
        `REG_EYE_CONTROL: fastEnable <= rxByte[`EYE_FAST_BIT];
        default: fastEnable <= fastEnable;
      endcase
    end
  end

  // ********************************
  // Datapath control outputs
  // ********************************
  always @(posedge mclk) begin
    if (reset) begin
      sigDetPower0 <= 1'b1;
      sigDetPower1 <= 1'b1;
      sigDetected0 <= 1'b0;
      sigDetected1 <= 1'b0;
      inputSelect <= 1'b0;
      eqPower0 <= 1'b1;
      eqPower1 <= 1'b0;
      eqBypass <= 1'b0;
      eqBoostStages <= `RST_EQ_BOOST;
      eqBoostSum <= 4'h0;
      cdrEnable <= 1'b1;
      cdrRoute <= 1'b1;
      eyePower <= 1'b0;
      eyeSpan <= 3'd0;
      eyePhase <= 6'd0;
      eyeVoltStep <= 6'd0;
      eyeActive <= 1'b0;
    end else begin
      sigDetPower0 <= pathControl[`CTL_DETECT0_POWER];
      sigDetPower1 <= pathControl[`CTL_DETECT1_POWER];
      // Comparator level is applied in the analog front end
      sigDetected0 <= det0Sync & pathControl[`CTL_DETECT0_POWER];
      sigDetected1 <= det1Sync & pathControl[`CTL_DETECT1_POWER];
      inputSelect <= pathControl[`CTL_INPUT_SELECT];
      eqPower0 <= ~pathControl[`CTL_INPUT_SELECT];
      eqPower1 <= pathControl[`CTL_INPUT_SELECT];
      eqBypass <= pathControl[`CTL_EQ_BYPASS];
      eqBoostStages <= pathControl[`CTL_INPUT_SELECT] ? eqBoost1 : eqBoost0;
      eqBoostSum <= boostSum(pathControl[`CTL_INPUT_SELECT] ? eqBoost1 : eqBoost0);
      cdrEnable <= (rateCode != `RATE_125M) && (rateCode != `RATE_1G25);
      cdrRoute <= ~pathControl[`CTL_CDR_AROUND];
      eyePower <= eyeSetup[`EYE_POWER_BIT];
      eyeSpan <= eyeSetup[3:1];
      eyePhase <= point[11:6];
      eyeVoltStep <= point[5:0];
      eyeActive <= eyeRun;
    end
  end

endmodule
